// >>> mcsr_pkg.sv
// constants shared by the monitor configuration and status register block
// assumes a single 10 MHz reference clock and an external serial engine
// that turns bus transactions into command-code strobes
package mcsr_pkg;

   // clock and conversion timing
   localparam int REF_CLK_HZ = 10_000_000;
   localparam int CONV_TIME_NS = 12800;
   localparam int GAP_TIME_NS = 6400;
   // least times, rounded up to whole cycles
   localparam int CONV_CYCLES = (CONV_TIME_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int GAP_CYCLES = (GAP_TIME_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;

   // command codes seen on the register port
   localparam logic [7:0] CMD_RD_STATUS1 = 8'h02;
   localparam logic [7:0] CMD_RD_CONFIG1 = 8'h03;
   localparam logic [7:0] CMD_WR_CONFIG1 = 8'h09;
   localparam logic [7:0] CMD_RD_STATUS2 = 8'h32;
   localparam logic [7:0] CMD_RD_CONFIG2 = 8'h33;
   localparam logic [7:0] CMD_WR_CONFIG2 = 8'h34;

   // reset values
   localparam logic [7:0] CONFIG1_RESET = 8'h00;
   localparam logic [7:0] CONFIG2_RESET = 8'h00;
   localparam logic [7:0] STATUS1_RESET = 8'h00;
   localparam logic [3:0] STATUS2_RESET = 4'h0;
   localparam logic [2:0] OVERTEMP_RESET = 3'h0;
   localparam logic [7:0] READ_RESET = 8'h00;

   // alert_mask_and_standby_config fields
   localparam int CFG1_MASK_ALL = 7;
   localparam int CFG1_STANDBY = 6;
   localparam int CFG1_MASK_REMOTE1 = 5;
   localparam int CFG1_MASK_REMOTE2 = 4;
   localparam int CFG1_MASK_VOLTAGE_INPUT_3 = 3;
   localparam int CFG1_MASK_VOLTAGE_INPUT_2 = 2;
   localparam int CFG1_MASK_VOLTAGE_INPUT_1 = 1;
   localparam int CFG1_MASK_SUPPLY = 0;

   // measurement_disable_config: reserved bit
   localparam int CFG2_RESERVED = 0;

   // temperature_trip_status fields
   localparam int ST1_BUSY = 7;
   localparam int ST1_INTERNAL_HIGH = 6;
   localparam int ST1_INTERNAL_LOW = 5;
   localparam int ST1_REMOTE1_HIGH = 4;
   localparam int ST1_REMOTE1_LOW = 3;
   localparam int ST1_REMOTE1_DIODE = 2;
   localparam int ST1_REMOTE2_HIGH = 1;
   localparam int ST1_REMOTE2_LOW = 0;

   // overtemp_voltage_status window trip fields (low nibble)
   localparam int ST2_VOLTAGE_INPUT_3 = 3;
   localparam int ST2_VOLTAGE_INPUT_2 = 2;
   localparam int ST2_VOLTAGE_INPUT_1 = 1;
   localparam int ST2_SUPPLY = 0;

   // conversion channels; disable bit of channel i is config2 bit (7 - i)
   localparam int NUM_CH = 7;
   localparam logic [2:0] CH_REMOTE1 = 3'h0;
   localparam logic [2:0] CH_REMOTE2 = 3'h1;
   localparam logic [2:0] CH_INTERNAL = 3'h2;
   localparam logic [2:0] CH_VOLTAGE_INPUT_3 = 3'h3;
   localparam logic [2:0] CH_VOLTAGE_INPUT_2 = 3'h4;
   localparam logic [2:0] CH_VOLTAGE_INPUT_1 = 3'h5;
   localparam logic [2:0] CH_SUPPLY = 3'h6;

   // over-temperature input order
   localparam int OT_INTERNAL = 0;
   localparam int OT_REMOTE1 = 1;
   localparam int OT_REMOTE2 = 2;

endpackage

// >>> mcsr_sync.sv
// two-flop synchroniser for a bundle of unrelated level inputs
// assumes each bit is a slow level; no bus coherency across bits
`timescale 1ns/100ps
module mcsr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic refClk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge refClk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end

   assign syncOut = sync_q;
endmodule

// >>> mcsr_conv_seq.sv
// round-robin conversion sequencer: walks the seven channels, skips
// disabled ones, rests between rounds, stops at once in standby
// assumes the analogue converter finishes within convCycles
`timescale 1ns/100ps
module mcsr_conv_seq
   import mcsr_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES,
   parameter int GAP_LEN = GAP_CYCLES
) (
   input wire logic refClk,
   input wire logic rst,
   input wire logic runEnable,
   input wire logic [NUM_CH-1:0] chanDisable,
   output logic [2:0] chanSel,
   output logic convStart,
   output logic convDone,
   output logic busy
);
   typedef enum logic [3:0] {
      MCSR_IDLE = 4'b0001,
      MCSR_SCAN = 4'b0010,
      MCSR_CONV = 4'b0100,
      MCSR_GAP = 4'b1000
   } mcsr_seq_t;

   mcsr_seq_t state_q, state_d;
   logic [2:0] chan_q, chan_d;
   logic [15:0] count_q, count_d;
   logic start_d, start_q;

   // next state; standby drops everything the same cycle
   always_comb begin
      state_d = state_q;
      chan_d = chan_q;
      count_d = count_q;
      start_d = 1'b0;
      convDone = 1'b0;
      if (!runEnable) begin
         state_d = MCSR_IDLE;
         chan_d = CH_REMOTE1;
         count_d = '0;
      end else begin
         case (state_q)
            MCSR_IDLE: begin
               state_d = MCSR_SCAN;
               chan_d = CH_REMOTE1;
            end
            MCSR_SCAN: begin
               // disabled channels are passed over, one per cycle
               if (!chanDisable[chan_q]) begin
                  state_d = MCSR_CONV;
                  count_d = '0;
                  start_d = 1'b1;
               end else if (chan_q == CH_SUPPLY) begin
                  state_d = MCSR_GAP;
                  count_d = '0;
               end else begin
                  chan_d = chan_q + 3'h1;
               end
            end
            MCSR_CONV: begin
               if (count_q == 16'(CONV_LEN - 1)) begin
                  convDone = 1'b1;
                  count_d = '0;
                  if (chan_q == CH_SUPPLY) begin
                     state_d = MCSR_GAP;
                  end else begin
                     chan_d = chan_q + 3'h1;
                     state_d = MCSR_SCAN;
                  end
               end else begin
                  count_d = count_q + 16'h0001;
               end
            end
            MCSR_GAP: begin
               // idle time between rounds shows busy low
               if (count_q == 16'(GAP_LEN - 1)) begin
                  state_d = MCSR_SCAN;
                  chan_d = CH_REMOTE1;
                  count_d = '0;
               end else begin
                  count_d = count_q + 16'h0001;
               end
            end
            default: begin
               state_d = MCSR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge refClk or posedge rst) begin
      if (rst) begin
         state_q <= MCSR_IDLE;
         chan_q <= CH_REMOTE1;
         count_q <= '0;
         start_q <= 1'b0;
      end else begin
         state_q <= state_d;
         chan_q <= chan_d;
         count_q <= count_d;
         start_q <= start_d;
      end
   end

   assign chanSel = chan_q;
   assign convStart = start_q;
   assign busy = (state_q == MCSR_CONV);
endmodule

// >>> mcsr_monitor_regs.sv
// configuration and status registers of the temperature and voltage monitor
// assumes a serial engine on ref_clk that issues one-cycle command strobes,
// and limit comparators whose results arrive as asynchronous levels
`timescale 1ns/100ps

module mcsr_monitor_regs
   import mcsr_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES,
   parameter int GAP_LEN = GAP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] cmdCode,
   input wire logic cmdWrite,
   input wire logic cmdRead,
   input wire logic [7:0] cmdWrData,
   output logic [7:0] cmdRdData,
   output logic cmdRdValid,
   input wire logic [NUM_CH-1:0] cmpHighIn,
   input wire logic [NUM_CH-1:0] cmpLowIn,
   input wire logic [2:0] overtempIn,
   input wire logic remote1DiodeIn,
   input wire logic remote2DiodeIn,
   output logic [2:0] convChannel,
   output logic convStart,
   output logic resultUpdate,
   output logic convBusy,
   output logic standbyOut,
   output logic alertOut,
   output logic overtemp_output
);
   localparam int SYNC_W = 2 * NUM_CH + 5;

   // disable bit of a channel sits at the mirrored config two position
   function automatic logic [NUM_CH-1:0] chanDisables(input logic [7:0] cfg2);
      logic [NUM_CH-1:0] dis;
      dis = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         dis[i] = cfg2[7-i];
      end
      return dis;
   endfunction

   logic [SYNC_W-1:0] syncBus;
   logic [NUM_CH-1:0] cmpHigh;
   logic [NUM_CH-1:0] cmpLow;
   logic [2:0] overtempCmp;
   logic remote1_diode_fault;
   logic remote2_diode_fault;

   logic [7:0] cfg1_q, cfg1_d;
   logic [7:0] cfg2_q, cfg2_d;
   logic [7:0] trip1_q, trip1_d;
   logic [3:0] trip2_q, trip2_d;
   logic [2:0] otFlag_q, otFlag_d;
   logic [7:0] rdData_q, rdData_d;
   logic rdValid_q, rdValid_d;
   logic alert_q, alert_d;
   logic otOut_q, otOut_d;

   logic [NUM_CH-1:0] chanDisable;
   logic [2:0] seqChan;
   logic seqDone;
   logic seqBusy;
   logic doneValid;
   logic [7:0] status1;
   logic [7:0] status2;
   logic [7:0] set1;
   logic [3:0] set2;
   logic clr1;
   logic clr2;

   // comparator and diode levels come from the analogue side
   mcsr_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .refClk(ref_clk),
      .rst(rst),
      .asyncIn({cmpHighIn, cmpLowIn, overtempIn, remote1DiodeIn, remote2DiodeIn}),
      .syncOut(syncBus)
   );

   assign cmpHigh = syncBus[SYNC_W-1 -: NUM_CH];
   assign cmpLow = syncBus[NUM_CH+4 -: NUM_CH];
   assign overtempCmp = syncBus[4:2];
   assign remote1_diode_fault = syncBus[1];
   assign remote2_diode_fault = syncBus[0];

   assign chanDisable = chanDisables(cfg2_q);

   mcsr_conv_seq #(
      .CONV_LEN(CONV_LEN),
      .GAP_LEN(GAP_LEN)
   ) u_seq (
      .refClk(ref_clk),
      .rst(rst),
      .runEnable(!cfg1_q[CFG1_STANDBY]),
      .chanDisable(chanDisable),
      .chanSel(seqChan),
      .convStart(convStart),
      .convDone(seqDone),
      .busy(seqBusy)
   );

   // a channel disabled mid-conversion throws its result away
   assign doneValid = seqDone && !chanDisable[seqChan];
   assign resultUpdate = doneValid;
   assign convChannel = seqChan;
   assign convBusy = seqBusy;
   assign standbyOut = cfg1_q[CFG1_STANDBY];

   // configuration writes; reserved bit never stores
   always_comb begin
      cfg1_d = cfg1_q;
      cfg2_d = cfg2_q;
      if (cmdWrite && cmdCode == CMD_WR_CONFIG1) begin
         cfg1_d = cmdWrData;
      end else if (cmdWrite && cmdCode == CMD_WR_CONFIG2) begin
         cfg2_d = cmdWrData;
         cfg2_d[CFG2_RESERVED] = 1'b0;
      end
   end

   // trip events from the channel that just finished
   always_comb begin
      set1 = '0;
      set2 = '0;
      if (doneValid) begin
         case (seqChan)
            CH_INTERNAL: begin
               set1[ST1_INTERNAL_HIGH] = cmpHigh[CH_INTERNAL];
               set1[ST1_INTERNAL_LOW] = cmpLow[CH_INTERNAL];
            end
            CH_REMOTE1: begin
               set1[ST1_REMOTE1_HIGH] = cmpHigh[CH_REMOTE1];
               set1[ST1_REMOTE1_LOW] = cmpLow[CH_REMOTE1];
            end
            CH_REMOTE2: begin
               set1[ST1_REMOTE2_HIGH] = cmpHigh[CH_REMOTE2];
               set1[ST1_REMOTE2_LOW] = cmpLow[CH_REMOTE2];
            end
            CH_VOLTAGE_INPUT_3: begin
               set2[ST2_VOLTAGE_INPUT_3] = cmpHigh[CH_VOLTAGE_INPUT_3] | cmpLow[CH_VOLTAGE_INPUT_3];
            end
            CH_VOLTAGE_INPUT_2: begin
               set2[ST2_VOLTAGE_INPUT_2] = cmpHigh[CH_VOLTAGE_INPUT_2] | cmpLow[CH_VOLTAGE_INPUT_2];
            end
            CH_VOLTAGE_INPUT_1: begin
               set2[ST2_VOLTAGE_INPUT_1] = cmpHigh[CH_VOLTAGE_INPUT_1] | cmpLow[CH_VOLTAGE_INPUT_1];
            end
            CH_SUPPLY: begin
               set2[ST2_SUPPLY] = cmpHigh[CH_SUPPLY] | cmpLow[CH_SUPPLY];
            end
            default: begin
               set2 = '0;
            end
         endcase
      end
   end

   // read-to-clear; a trip landing in the read cycle survives for the next read
   assign clr1 = cmdRead && cmdCode == CMD_RD_STATUS1;
   assign clr2 = cmdRead && cmdCode == CMD_RD_STATUS2;

   always_comb begin
      trip1_d = set1 | (trip1_q & ~{8{clr1}});
      trip1_d[ST1_BUSY] = 1'b0;
      trip1_d[ST1_REMOTE1_DIODE] = 1'b0;
      trip2_d = set2 | (trip2_q & ~{4{clr2}});
   end

   // over-temperature flags track each fresh measurement, set and clear alike
   always_comb begin
      otFlag_d = otFlag_q;
      if (doneValid && seqChan == CH_INTERNAL) begin
         otFlag_d[OT_INTERNAL] = overtempCmp[OT_INTERNAL];
      end else if (doneValid && seqChan == CH_REMOTE1) begin
         otFlag_d[OT_REMOTE1] = overtempCmp[OT_REMOTE1];
      end else if (doneValid && seqChan == CH_REMOTE2) begin
         otFlag_d[OT_REMOTE2] = overtempCmp[OT_REMOTE2];
      end
      otOut_d = |otFlag_q;
   end

   // status views; busy and diode bits are live, not latched
   always_comb begin
      status1 = trip1_q;
      status1[ST1_BUSY] = seqBusy;
      status1[ST1_REMOTE1_DIODE] = remote1_diode_fault;
      status2 = {otFlag_q[OT_INTERNAL], otFlag_q[OT_REMOTE1], otFlag_q[OT_REMOTE2],
                 remote2_diode_fault, trip2_q};
   end

   // read decode; unknown codes answer zero
   always_comb begin
      rdData_d = rdData_q;
      rdValid_d = 1'b0;
      if (cmdRead) begin
         rdValid_d = 1'b1;
         if (cmdCode == CMD_RD_STATUS1) begin
            rdData_d = status1;
         end else if (cmdCode == CMD_RD_STATUS2) begin
            rdData_d = status2;
         end else if (cmdCode == CMD_RD_CONFIG1) begin
            rdData_d = cfg1_q;
         end else if (cmdCode == CMD_RD_CONFIG2) begin
            rdData_d = cfg2_q;
         end else begin
            rdData_d = READ_RESET;
         end
      end
   end

   // alert: internal trips obey only mask-all; diode faults count with their channel
   always_comb begin
      alert_d = 1'b0;
      if (!cfg1_q[CFG1_MASK_ALL]) begin
         alert_d = trip1_q[ST1_INTERNAL_HIGH] | trip1_q[ST1_INTERNAL_LOW]
            | (!cfg1_q[CFG1_MASK_REMOTE1] & (trip1_q[ST1_REMOTE1_HIGH] | trip1_q[ST1_REMOTE1_LOW]
               | remote1_diode_fault))
            | (!cfg1_q[CFG1_MASK_REMOTE2] & (trip1_q[ST1_REMOTE2_HIGH] | trip1_q[ST1_REMOTE2_LOW]
               | remote2_diode_fault))
            | (!cfg1_q[CFG1_MASK_VOLTAGE_INPUT_3] & trip2_q[ST2_VOLTAGE_INPUT_3])
            | (!cfg1_q[CFG1_MASK_VOLTAGE_INPUT_2] & trip2_q[ST2_VOLTAGE_INPUT_2])
            | (!cfg1_q[CFG1_MASK_VOLTAGE_INPUT_1] & trip2_q[ST2_VOLTAGE_INPUT_1])
            | (!cfg1_q[CFG1_MASK_SUPPLY] & trip2_q[ST2_SUPPLY]);
      end
   end

   // all register state, cleared by power-on reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg1_q <= CONFIG1_RESET;
         cfg2_q <= CONFIG2_RESET;
         trip1_q <= STATUS1_RESET;
         trip2_q <= STATUS2_RESET;
         otFlag_q <= OVERTEMP_RESET;
         rdData_q <= READ_RESET;
         rdValid_q <= 1'b0;
         alert_q <= 1'b0;
         otOut_q <= 1'b0;
      end else begin
         cfg1_q <= cfg1_d;
         cfg2_q <= cfg2_d;
         trip1_q <= trip1_d;
         trip2_q <= trip2_d;
         otFlag_q <= otFlag_d;
         rdData_q <= rdData_d;
         rdValid_q <= rdValid_d;
         alert_q <= alert_d;
         otOut_q <= otOut_d;
      end
   end

   assign cmdRdData = rdData_q;
   assign cmdRdValid = rdValid_q;
   assign alertOut = alert_q;
   assign overtemp_output = otOut_q;
endmodule

// >>> mcsr_properties.sv
// port assertions for the monitor register block
// bound to mcsr_monitor_regs; config bytes are shadowed from write strobes
`timescale 1ns/100ps
module mcsr_properties
   import mcsr_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES,
   parameter int GAP_LEN = GAP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] cmdCode,
   input wire logic cmdWrite,
   input wire logic cmdRead,
   input wire logic [7:0] cmdWrData,
   input wire logic [7:0] cmdRdData,
   input wire logic cmdRdValid,
   input wire logic [2:0] convChannel,
   input wire logic convStart,
   input wire logic resultUpdate,
   input wire logic convBusy,
   input wire logic standbyOut,
   input wire logic alertOut
);
   logic [7:0] cfg1_q, cfg1_d, cfg2_q, cfg2_d, settle_q, settle_d;

   // shadow config; settle counts cycles since a disable change, as a conversion in flight may finish
   always_comb begin
      cfg1_d = cfg1_q;
      cfg2_d = cfg2_q;
      settle_d = (settle_q == 8'hFF) ? settle_q : settle_q + 8'h01;
      if (cmdWrite && cmdCode == CMD_WR_CONFIG1) begin
         cfg1_d = cmdWrData;
      end
      if (cmdWrite && cmdCode == CMD_WR_CONFIG2) begin
         cfg2_d = cmdWrData & 8'hFE;
         settle_d = 8'h00;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg1_q <= 8'h00;
         cfg2_q <= 8'h00;
         settle_q <= 8'h00;
      end else begin
         cfg1_q <= cfg1_d;
         cfg2_q <= cfg2_d;
         settle_q <= settle_d;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_RD_VALID: assert property (cmdRead |=> cmdRdValid)
      else $error("read strobe without valid");
   AST_NO_STRAY_VALID: assert property (!cmdRead |=> !cmdRdValid)
      else $error("valid without read strobe");
   AST_CFG1_READBACK: assert property (cmdRead && cmdCode == CMD_RD_CONFIG1 |=> cmdRdData == $past(cfg1_q))
      else $error("config1 readback wrong");
   AST_CFG2_RESERVED: assert property (cmdRead && cmdCode == CMD_RD_CONFIG2 |=> cmdRdData == $past(cfg2_q))
      else $error("config2 readback wrong");
   AST_BUSY_BIT: assert property (cmdRead && cmdCode == CMD_RD_STATUS1 |=> cmdRdData[ST1_BUSY] == $past(convBusy))
      else $error("busy bit disagrees with converter");
   AST_STANDBY_LEVEL: assert property (cmdWrite && cmdCode == CMD_WR_CONFIG1 |=> standbyOut == cfg1_q[CFG1_STANDBY])
      else $error("standby level wrong");
   AST_STANDBY_HALT: assert property (standbyOut |=> !convBusy && !convStart)
      else $error("converting in standby");
   AST_STANDBY_NO_RESULT: assert property (standbyOut && $past(standbyOut) |-> !resultUpdate)
      else $error("result taken in standby");
   AST_RESULT_ENDS_BUSY: assert property (resultUpdate |-> convBusy ##1 !convBusy)
      else $error("result not at end of conversion");
   AST_DISABLED_SKIPPED: assert property (resultUpdate && int'(settle_q) > CONV_LEN + 4 |-> !cfg2_q[7 - convChannel])
      else $error("disabled channel converted");
   AST_MASK_ALL: assert property (cfg1_q[CFG1_MASK_ALL] && $past(cfg1_q[CFG1_MASK_ALL]) |-> !alertOut)
      else $error("alert while all masked");
endmodule

// >>> mcsr_host_model.sv
// host side model: single-cycle command strobes from the serial engine
// assumes the block answers a read one cycle after the strobe
`timescale 1ns/100ps
module mcsr_host_model (
   input wire logic ref_clk,
   output logic [7:0] cmdCode,
   output logic cmdWrite,
   output logic cmdRead,
   output logic [7:0] cmdWrData,
   input wire logic [7:0] cmdRdData,
   input wire logic cmdRdValid
);
   // idle lines start defined
   initial begin
      cmdCode = 8'h00;
      cmdWrite = 1'b0;
      cmdRead = 1'b0;
      cmdWrData = 8'h00;
   end

   // strobe spans one rising edge; lines are scrambled afterwards so stale values are not trusted
   task automatic wr(input logic [7:0] code, input logic [7:0] data);
      @(negedge ref_clk);
      cmdCode = code;
      cmdWrData = data;
      cmdWrite = 1'b1;
      @(negedge ref_clk);
      cmdWrite = 1'b0;
      cmdCode = ~code;
      cmdWrData = ~data;
   endtask

   // data without valid comes back unknown so any compare fails
   task automatic rd(input logic [7:0] code, output logic [7:0] data);
      @(negedge ref_clk);
      cmdCode = code;
      cmdRead = 1'b1;
      @(negedge ref_clk);
      cmdRead = 1'b0;
      cmdCode = ~code;
      data = cmdRdValid ? cmdRdData : 8'hXX;
   endtask
endmodule

// >>> testbench.sv
// self-checking bench for the monitor register block
// assumes mcsr_host_model for commands; conversion counts shortened to 4 and 2
`timescale 1ns/100ps
module testbench;
   import mcsr_pkg::*;
   localparam int CL = 4;
   localparam int GL = 2;
   localparam int ROUND = 80; // about two full scans plus synchroniser delay
   logic ref_clk, rst, cmdWrite, cmdRead, cmdRdValid, r1Diode, r2Diode;
   logic [7:0] cmdCode, cmdWrData, cmdRdData;
   logic [6:0] cmpHigh, cmpLow;
   logic [2:0] otIn, convChannel;
   logic convStart, resultUpdate, convBusy, standbyOut, alertOut, overtemp_output;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   mcsr_monitor_regs #(.CONV_LEN(CL), .GAP_LEN(GL)) u_mcsr_monitor_regs (
      .ref_clk(ref_clk), .rst(rst), .cmdCode(cmdCode), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
      .cmdWrData(cmdWrData), .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .cmpHighIn(cmpHigh),
      .cmpLowIn(cmpLow), .overtempIn(otIn), .remote1DiodeIn(r1Diode), .remote2DiodeIn(r2Diode),
      .convChannel(convChannel), .convStart(convStart), .resultUpdate(resultUpdate), .convBusy(convBusy),
      .standbyOut(standbyOut), .alertOut(alertOut), .overtemp_output(overtemp_output));

   mcsr_host_model u_mcsr_host_model (.ref_clk(ref_clk), .cmdCode(cmdCode), .cmdWrite(cmdWrite),
      .cmdRead(cmdRead), .cmdWrData(cmdWrData), .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid));

   // free-running reference clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] c, input logic [7:0] v);
      u_mcsr_host_model.wr(c, v);
   endtask

   task automatic rd(input logic [7:0] c, output logic [7:0] v);
      u_mcsr_host_model.rd(c, v);
   endtask

   task automatic test_reset();
      logic [7:0] d;
      rd(CMD_RD_CONFIG1, d);
      check("config1", d, 8'h00);
      rd(CMD_RD_CONFIG2, d);
      check("config2", d, 8'h00);
      rd(CMD_RD_STATUS1, d);
      check("status1", d & 8'h7F, 8'h00);
      rd(CMD_RD_STATUS2, d);
      check("status2", d, 8'h00);
      $display("test_reset done");
   endtask

   task automatic test_config();
      logic [7:0] d;
      wr(CMD_WR_CONFIG1, 8'hBF);
      rd(CMD_RD_CONFIG1, d);
      check("config1", d, 8'hBF);
      wr(CMD_WR_CONFIG2, 8'hFF);
      rd(CMD_RD_CONFIG2, d);
      check("config2", d, 8'hFE);
      rd(8'h7E, d);
      check("unmapped", d, 8'h00);
      wr(CMD_WR_CONFIG1, 8'h00);
      wr(CMD_WR_CONFIG2, 8'h00);
      $display("test_config done");
   endtask

   // status1 must be seen both as busy-only and as all clear
   task automatic test_busy();
      logic [7:0] d;
      logic s80, s00;
      s80 = 1'b0;
      s00 = 1'b0;
      for (int i = 0; i < 200 && !(s80 && s00); i++) begin
         rd(CMD_RD_STATUS1, d);
         s80 = s80 | (d === 8'h80);
         s00 = s00 | (d === 8'h00);
      end
      check("busy read", {7'h00, s80}, 8'h01);
      check("idle read", {7'h00, s00}, 8'h01);
      $display("test_busy done");
   endtask

   // high trip on every channel, then low trip on every channel: flag, alert, own mask, read clear
   task automatic test_trips();
      logic [7:0] d, e1, e2, m;
      for (int k = 0; k < 2; k++) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            e1 = ((ch == 0) ? 8'h10 : (ch == 1) ? 8'h02 : (ch == 2) ? 8'h40 : 8'h00) >> k;
            e2 = (ch > 2) ? (8'h01 << (6 - ch)) : 8'h00;
            m = (ch < 2) ? (8'h20 >> ch) : (ch == 2) ? 8'h80 : (8'h08 >> (ch - 3));
            cmpHigh[ch] = (k == 0);
            cmpLow[ch] = (k == 1);
            repeat (ROUND) @(negedge ref_clk);
            cmpHigh = 7'h00;
            cmpLow = 7'h00;
            check("alert", {7'h00, alertOut}, 8'h01);
            wr(CMD_WR_CONFIG1, m);
            repeat (3) @(negedge ref_clk);
            check("masked alert", {7'h00, alertOut}, 8'h00);
            wr(CMD_WR_CONFIG1, 8'h00);
            rd(CMD_RD_STATUS1, d);
            check("status1 trip", d & 8'h7B, e1);
            rd(CMD_RD_STATUS2, d);
            check("status2 trip", d & 8'h0F, e2);
            rd(CMD_RD_STATUS1, d);
            check("status1 cleared", d & 8'h7B, 8'h00);
            rd(CMD_RD_STATUS2, d);
            check("status2 cleared", d & 8'h0F, 8'h00);
         end
      end
      $display("test_trips done");
   endtask

   // all off: nothing starts or latches; remote one off alone: the others still trip
   task automatic test_disable();
      logic [7:0] d;
      int n;
      n = 0;
      wr(CMD_WR_CONFIG2, 8'hFE);
      repeat (20) @(negedge ref_clk);
      cmpHigh = 7'h7F;
      for (int i = 0; i < ROUND; i++) begin
         @(negedge ref_clk);
         n = n + int'(convStart) + int'(resultUpdate);
      end
      cmpHigh = 7'h00;
      check("disabled starts", n[7:0], 8'h00);
      rd(CMD_RD_STATUS1, d);
      check("disabled status1", d & 8'h7B, 8'h00);
      rd(CMD_RD_STATUS2, d);
      check("disabled status2", d, 8'h00);
      wr(CMD_WR_CONFIG2, 8'h80);
      cmpHigh = 7'h7F;
      repeat (ROUND) @(negedge ref_clk);
      cmpHigh = 7'h00;
      // let the synchroniser drain so no trip lands in the clearing read
      repeat (3) @(negedge ref_clk);
      rd(CMD_RD_STATUS1, d);
      check("remote1 off status1", d & 8'h7B, 8'h42);
      rd(CMD_RD_STATUS2, d);
      check("remote1 off status2", d & 8'h0F, 8'h0F);
      wr(CMD_WR_CONFIG2, 8'h00);
      $display("test_disable done");
   endtask

   task automatic test_overtemp();
      logic [7:0] d;
      otIn = 3'h7;
      r1Diode = 1'b1;
      r2Diode = 1'b1;
      repeat (ROUND) @(negedge ref_clk);
      rd(CMD_RD_STATUS2, d);
      check("diode2", d & 8'h10, 8'h10);
      check("overtemp all", d, 8'hF0);
      check("overtemp pin", {7'h00, overtemp_output}, 8'h01);
      rd(CMD_RD_STATUS1, d);
      check("diode1", d & 8'h7F, 8'h04);
      otIn = 3'h5;
      r1Diode = 1'b0;
      r2Diode = 1'b0;
      repeat (ROUND) @(negedge ref_clk);
      rd(CMD_RD_STATUS2, d);
      check("overtemp part", d, 8'hA0);
      otIn = 3'h0;
      repeat (ROUND) @(negedge ref_clk);
      rd(CMD_RD_STATUS2, d);
      check("overtemp clear", d, 8'h00);
      check("overtemp pin off", {7'h00, overtemp_output}, 8'h00);
      $display("test_overtemp done");
   endtask

   task automatic test_standby();
      logic [7:0] d;
      int n;
      wr(CMD_WR_CONFIG1, 8'h40);
      check("standby", {7'h00, standbyOut}, 8'h01);
      repeat (ROUND) @(negedge ref_clk);
      rd(CMD_RD_STATUS1, d);
      check("standby status1", d, 8'h00);
      wr(CMD_WR_CONFIG1, 8'h00);
      n = 0;
      while (convBusy !== 1'b1 && n < ROUND) begin
         @(negedge ref_clk);
         n++;
      end
      check("resumed", {7'h00, convBusy}, 8'h01);
      $display("test_standby done");
   endtask

   task automatic finish_test();
      $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 8000) begin
         num_errors++;
         finish_test();
      end
   end

   initial begin
      rst = 1'b1;
      cmpHigh = 7'h00;
      cmpLow = 7'h00;
      otIn = 3'h0;
      r1Diode = 1'b0;
      r2Diode = 1'b0;
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      test_reset();
      test_config();
      test_busy();
      test_trips();
      test_disable();
      test_overtemp();
      test_standby();
      finish_test();
   end
endmodule

bind mcsr_monitor_regs mcsr_properties #(.CONV_LEN(CONV_LEN), .GAP_LEN(GAP_LEN)) u_mcsr_properties (
   .ref_clk(ref_clk), .rst(rst), .cmdCode(cmdCode), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
   .cmdWrData(cmdWrData), .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .convChannel(convChannel),
   .convStart(convStart), .resultUpdate(resultUpdate), .convBusy(convBusy), .standbyOut(standbyOut),
   .alertOut(alertOut));
